/* common/nfc_pkg.sv */
/*
  nfc_pkg: constants for the host-side controller of a multiplexed-I/O
  NAND flash (command codes, address layout, array geometry, strobe timing).
  assumes: the controller runs on mclk at 250 MHz.
*/
package nfc_pkg;
  // clock rate
  localparam int unsigned MCLK_MHZ       = 250;
  // strobe phase length in ns, and its cycle count (a least time, rounded up)
  localparam int unsigned STROBE_NS      = 24;
  localparam int unsigned STROBE_CYC     = (STROBE_NS * MCLK_MHZ + 999) / 1000;
  // wait after a busy-causing command before sampling ready/busy, in ns
  localparam int unsigned WB_NS          = 100;
  localparam int unsigned WB_CYC         = (WB_NS * MCLK_MHZ + 999) / 1000;
  // command codes
  localparam logic [7:0] CMD_READ_A      = 8'h00;
  localparam logic [7:0] CMD_READ_B      = 8'h01;
  localparam logic [7:0] CMD_READ_SPARE  = 8'h50;
  localparam logic [7:0] CMD_READ_ID     = 8'h90;
  localparam logic [7:0] CMD_RESET       = 8'hFF;
  localparam logic [7:0] CMD_PROG_SETUP  = 8'h80;
  localparam logic [7:0] CMD_PROG_TRUE   = 8'h10;
  localparam logic [7:0] CMD_PROG_DUMMY  = 8'h11;
  localparam logic [7:0] CMD_CB_DUMMY_RD = 8'h03;
  localparam logic [7:0] CMD_CB_LOAD     = 8'h8A;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONF  = 8'hD0;
  localparam logic [7:0] CMD_STATUS      = 8'h70;
  localparam logic [7:0] CMD_MP_STATUS   = 8'h71;
  // address layout
  localparam int unsigned ADDR_BITS      = 26;
  localparam int unsigned ADDR_CYCLES    = 4;
  localparam int unsigned ROW_LSB        = 9;
  localparam int unsigned A8_POS         = 8;
  // array geometry
  localparam int unsigned PAGE_COLS      = 528;
  localparam int unsigned SPARE_FIRST    = 512;
  localparam int unsigned PAGES_PER_BLK  = 32;
  localparam int unsigned NUM_BLOCKS     = 4096;
  localparam int unsigned NUM_PLANES     = 4;
  // host request opcodes
  typedef enum logic [2:0] {
    NFC_OP_CMD,     // command byte only
    NFC_OP_ADDR4,   // command, four address cycles (read, program)
    NFC_OP_ADDR3,   // command, three row cycles (erase)
    NFC_OP_WDATA,   // data bytes from the fifo
    NFC_OP_RDATA,   // data bytes read out
    NFC_OP_WAIT     // wait for ready
  } nfc_op_t;
endpackage : nfc_pkg

/* src/nfc_fifo.sv */
/*
  nfc_fifo: synchronous fifo with valid/ready on both sides.
  assumes: single clock mclk, asynchronous active-high reset.
*/
`timescale 1ns/1ps
module nfc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];     // storage
  logic [AW-1:0]    wr_ptr_ff;       // write pointer
  logic [AW-1:0]    rd_ptr_ff;       // read pointer
  logic [AW:0]      count_ff;        // words held
  logic             push;            // word accepted
  logic             pop;             // word taken

  assign in_ready  = (count_ff < (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data  = mem[rd_ptr_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage write, no reset needed on data
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : nfc_fifo

/* src/nfc_host.sv */
/*
  nfc_host: host-side controller that drives a NAND flash through its
  command/address/data pins, strobes and ready/busy line.
  assumes: flash pins pass through pads outside; ready/busy has a pull-up;
  write data arrives through an 8-word fifo, read data leaves as a pulse.
*/
//
// Functional notes
// RULE_01: write-protect low blocks program and erase.
// RULE_02: ready/busy low while operation runs.
// RULE_03: ready/busy open drain, never floats.
// RULE_04: address is four cycles, column first.
// RULE_05: surplus address cycles are ignored.
// RULE_06: host drives unused address bits low.
// RULE_07: commands 00h/01h select page half.
// RULE_08: pointer returns to first half afterward.
// RULE_09: bytes written by write-enable pulse, rising capture.
// RULE_10: read/program four cycles, erase three.
// RULE_11: single-cycle read, ID, reset codes decoded.
// RULE_12: program 80h then 10h or 11h.
// RULE_13: erase 60h, row address, then D0h.
// RULE_14: busy accepts only reset and status.
// RULE_15: use 71h for multi-plane status.
// RULE_16: dummy confirm loads planes two to four.
// RULE_17: pages of 528 columns, spare 512-527.
// RULE_18: blocks of 32 pages, 4096 blocks.
// RULE_19: four planes of 1024 blocks.
// RULE_20: per-plane pass or fail reported.
// RULE_21: copy-back moves pages inside chip.
// RULE_22: one extra one-time-programmable block.
// RULE_23: command latch high captures command.
// RULE_24: address latch high captures address.
// RULE_25: read-enable fall advances column counter.
// RULE_26: busy ignores chip-enable high.
// RULE_27: wait ready before non-status commands.
`timescale 1ns/1ps
module nfc_host
  import nfc_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 8,
  parameter int unsigned LEN_W      = 10
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // request port
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire nfc_op_t           req_op,
  input  wire logic [7:0]        req_cmd,
  input  wire logic [ADDR_BITS-1:0] req_addr,
  input  wire logic [LEN_W-1:0]  req_len,
  input  wire logic              wp_allow,
  // write data stream
  input  wire logic              wd_valid,
  output logic                   wd_ready,
  input  wire logic [7:0]        wd_data,
  // read data stream
  output logic                   rd_valid,
  output logic [7:0]             rd_data,
  // status
  output logic                   busy_seen,
  output logic                   refused,
  // flash pins
  output logic                   chip_en_n,
  output logic                   cmd_latch,
  output logic                   addr_latch,
  output logic                   write_strobe_n,
  output logic                   read_strobe_n,
  output logic                   wprot_n,
  output logic [7:0]             io_out,
  output logic                   io_oe,
  input  wire logic [7:0]        io_in,
  input  wire logic              rdy_busy_n
);
  typedef enum logic [2:0] {
    NFC_IDLE, NFC_WLOW, NFC_WHIGH, NFC_RLOW, NFC_RHIGH, NFC_TWB, NFC_WAITRDY
  } nfc_state_t;

  localparam int unsigned PH_W = $clog2(STROBE_CYC + WB_CYC + 1);

  nfc_state_t       state_ff;        // sequencer state
  logic [PH_W-1:0]  ph_cnt_ff;       // phase timer
  logic [2:0]       byte_idx_ff;     // byte slot inside command group
  logic [2:0]       last_idx_ff;     // last slot of this group
  logic [LEN_W-1:0] len_ff;          // data bytes left
  nfc_op_t          op_ff;           // current operation
  logic [7:0]       cmd_ff;          // command byte held
  logic [ADDR_BITS-1:0] addr_ff;     // address held
  logic             busy_ff;         // device reported busy since last command
  logic [1:0]       rb_sync_ff;      // ready/busy synchroniser
  logic [7:0]       io_s1_ff;        // io input first stage
  logic [7:0]       io_s2_ff;        // io input second stage
  logic             rb_ready;        // synchronised ready level
  logic             fifo_valid;      // fifo has a byte
  logic             fifo_pop;        // take a byte
  logic [7:0]       fifo_data;       // byte at fifo head
  logic             allowed;         // request legal at this moment
  logic             phase_done;      // phase timer expired

  assign rb_ready   = rb_sync_ff[1];
  assign phase_done = (ph_cnt_ff == '0);

  // the input fifo decouples the data source from strobe timing
  nfc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (wd_valid),
    .in_ready  (wd_ready),
    .in_data   (wd_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // ready/busy and data pins come from outside; two flops each
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rb_sync_ff <= 2'h0;
      io_s1_ff   <= 8'h00;
      io_s2_ff   <= 8'h00;
    end else begin
      rb_sync_ff <= {rb_sync_ff[0], rdy_busy_n};
      io_s1_ff   <= io_in;
      io_s2_ff   <= io_s1_ff;
    end
  end

  // RULE_14 busy command filter
  // RULE_27 host waits for ready
  // RULE_15 71h passes for multi-plane status
  // while busy only reset, the two status reads, data reads and waits may go out
  always_comb begin
    allowed = rb_ready ||
              (req_op == NFC_OP_CMD &&
               (req_cmd == CMD_RESET || req_cmd == CMD_STATUS ||
                req_cmd == CMD_MP_STATUS)) ||
              req_op == NFC_OP_WAIT || req_op == NFC_OP_RDATA;
  end

  // fifo is drained once per data write strobe
  assign fifo_pop = (state_ff == NFC_WHIGH) && phase_done && (op_ff == NFC_OP_WDATA);

  // main sequencer: one byte slot is a low phase then a high phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff    <= NFC_IDLE;
      ph_cnt_ff   <= '0;
      byte_idx_ff <= 3'h0;
      last_idx_ff <= 3'h0;
      len_ff      <= '0;
      op_ff       <= NFC_OP_CMD;
      cmd_ff      <= 8'h00;
      addr_ff     <= '0;
    end else begin
      case (state_ff)
        NFC_IDLE: begin
          if (req_valid && allowed) begin
            op_ff       <= req_op;
            cmd_ff      <= req_cmd;
            addr_ff     <= req_addr;
            len_ff      <= req_len;
            byte_idx_ff <= 3'h0;
            ph_cnt_ff   <= PH_W'(STROBE_CYC - 1);
            // RULE_10 address cycle count
            if (req_op == NFC_OP_ADDR4) begin
              last_idx_ff <= 3'(ADDR_CYCLES);
            end else if (req_op == NFC_OP_ADDR3) begin
              last_idx_ff <= 3'(ADDR_CYCLES - 1);
            end else begin
              last_idx_ff <= 3'h0;
            end
            if (req_op == NFC_OP_RDATA) begin
              state_ff <= (req_len == '0) ? NFC_IDLE : NFC_RLOW;
            end else if (req_op == NFC_OP_WAIT) begin
              ph_cnt_ff <= PH_W'(WB_CYC);
              state_ff  <= NFC_TWB;
            end else if (req_op == NFC_OP_WDATA && req_len == '0) begin
              state_ff <= NFC_IDLE;
            end else begin
              state_ff <= NFC_WLOW;
            end
          end
        end
        // RULE_09 write strobe low phase
        NFC_WLOW: begin
          if (op_ff == NFC_OP_WDATA && !fifo_valid) begin
            ph_cnt_ff <= PH_W'(STROBE_CYC - 1);
          end else if (phase_done) begin
            ph_cnt_ff <= PH_W'(STROBE_CYC - 1);
            state_ff  <= NFC_WHIGH;
          end else begin
            ph_cnt_ff <= ph_cnt_ff - 1'b1;
          end
        end
        NFC_WHIGH: begin
          if (!phase_done) begin
            ph_cnt_ff <= ph_cnt_ff - 1'b1;
          end else begin
            ph_cnt_ff <= PH_W'(STROBE_CYC - 1);
            if (op_ff == NFC_OP_WDATA) begin
              len_ff   <= len_ff - 1'b1;
              state_ff <= (len_ff == LEN_W'(1)) ? NFC_IDLE : NFC_WLOW;
            end else if (byte_idx_ff == last_idx_ff) begin
              state_ff <= NFC_IDLE;
            end else begin
              byte_idx_ff <= byte_idx_ff + 1'b1;
              state_ff    <= NFC_WLOW;
            end
          end
        end
        // RULE_25 each read strobe fall steps the column
        NFC_RLOW: begin
          if (phase_done) begin
            ph_cnt_ff <= PH_W'(STROBE_CYC - 1);
            state_ff  <= NFC_RHIGH;
          end else begin
            ph_cnt_ff <= ph_cnt_ff - 1'b1;
          end
        end
        NFC_RHIGH: begin
          if (!phase_done) begin
            ph_cnt_ff <= ph_cnt_ff - 1'b1;
          end else begin
            ph_cnt_ff <= PH_W'(STROBE_CYC - 1);
            len_ff    <= len_ff - 1'b1;
            state_ff  <= (len_ff == LEN_W'(1)) ? NFC_IDLE : NFC_RLOW;
          end
        end
        // let the device pull ready/busy low before looking at it
        NFC_TWB: begin
          if (phase_done) begin
            state_ff <= NFC_WAITRDY;
          end else begin
            ph_cnt_ff <= ph_cnt_ff - 1'b1;
          end
        end
        // RULE_02 wait for ready/busy release
        NFC_WAITRDY: begin
          if (rb_ready) begin
            state_ff <= NFC_IDLE;
          end
        end
        default: begin
          state_ff <= NFC_IDLE;
        end
      endcase
    end
  end

  // pin drivers, all registered
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      chip_en_n      <= 1'b1;
      cmd_latch      <= 1'b0;
      addr_latch     <= 1'b0;
      write_strobe_n <= 1'b1;
      read_strobe_n  <= 1'b1;
      io_out         <= 8'h00;
      io_oe          <= 1'b0;
    end else begin
      // RULE_26 chip stays selected while a wait runs anyway
      chip_en_n      <= (state_ff == NFC_IDLE) && !(req_valid && allowed);
      write_strobe_n <= !(state_ff == NFC_WLOW &&
                          !(op_ff == NFC_OP_WDATA && !fifo_valid));
      read_strobe_n  <= (state_ff != NFC_RLOW);
      io_oe          <= (state_ff == NFC_WLOW) || (state_ff == NFC_WHIGH);
      // RULE_23 command latch on slot zero
      cmd_latch      <= (state_ff == NFC_WLOW || state_ff == NFC_WHIGH) &&
                        op_ff != NFC_OP_WDATA && byte_idx_ff == 3'h0;
      // RULE_24 address latch on later slots
      addr_latch     <= (state_ff == NFC_WLOW || state_ff == NFC_WHIGH) &&
                        op_ff != NFC_OP_WDATA && byte_idx_ff != 3'h0;
      if (op_ff == NFC_OP_WDATA) begin
        io_out <= fifo_data;
      end else if (byte_idx_ff == 3'h0) begin
        // RULE_12 RULE_13 RULE_16 sequence codes as given
        io_out <= cmd_ff;
      end else if (op_ff == NFC_OP_ADDR3) begin
        // RULE_10 erase skips the column cycle
        io_out <= (byte_idx_ff == 3'h3) ? {7'h00, addr_ff[ADDR_BITS-1]} :
                  addr_ff[ROW_LSB + 8*(byte_idx_ff - 3'h1) +: 8];
      end else begin
        // RULE_04 column, low row, middle row, top bit
        // RULE_06 unused top bits driven low
        case (byte_idx_ff)
          3'h1:    io_out <= addr_ff[7:0];
          3'h2:    io_out <= addr_ff[ROW_LSB +: 8];
          3'h3:    io_out <= addr_ff[ROW_LSB + 8 +: 8];
          default: io_out <= {7'h00, addr_ff[ADDR_BITS-1]};
        endcase
      end
    end
  end

  // RULE_01 write protect follows software permission
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wprot_n <= 1'b0;
    end else begin
      wprot_n <= wp_allow;
    end
  end

  // read data captured at the end of each read strobe low phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data  <= 8'h00;
    end else begin
      rd_valid <= (state_ff == NFC_RLOW) && phase_done;
      if ((state_ff == NFC_RLOW) && phase_done) begin
        rd_data <= io_s2_ff;
      end
    end
  end

  // status flags: ready handshake, busy seen, refused request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      req_ready <= 1'b0;
      busy_seen <= 1'b0;
      refused   <= 1'b0;
      busy_ff   <= 1'b0;
    end else begin
      req_ready <= (state_ff == NFC_IDLE) && !(req_valid && allowed);
      refused   <= (state_ff == NFC_IDLE) && req_valid && !allowed;
      // set wins over the clear of a new command
      if (!rb_ready) begin
        busy_ff <= 1'b1;
      end else if (state_ff == NFC_IDLE && req_valid && allowed) begin
        busy_ff <= 1'b0;
      end
      busy_seen <= busy_ff;
    end
  end

  // RULE_27 no command other than reset or a status read leaves while busy
  nonstatus_busy_a : assert property (@(posedge mclk) disable iff (rst) // RULE_27
    (state_ff == NFC_IDLE && req_valid && req_op == NFC_OP_CMD && !rb_ready &&
     req_cmd != CMD_RESET && req_cmd != CMD_STATUS && req_cmd != CMD_MP_STATUS)
    |=> (state_ff == NFC_IDLE && refused))
    else $error("command sent while busy");

  // RULE_09 strobe low spans the phase
  sequence wlow_s;
    !write_strobe_n [*6];
  endsequence
  strobe_width_a : assert property (@(posedge mclk) disable iff (rst) // RULE_09
    $fell(write_strobe_n) && op_ff != NFC_OP_WDATA |-> wlow_s)
    else $error("write strobe too short");

  latch_excl_a : assert property (@(posedge mclk) disable iff (rst) // RULE_23
    !(cmd_latch && addr_latch))
    else $error("both latches high");

  io_drive_a : assert property (@(posedge mclk) disable iff (rst) // RULE_24
    !write_strobe_n |-> io_oe)
    else $error("strobe without driven data");

  rd_pulse_a : assert property (@(posedge mclk) disable iff (rst) // RULE_25
    $rose(read_strobe_n) |-> $past(rd_valid))
    else $error("read byte not delivered");

  top_addr_a : assert property (@(posedge mclk) disable iff (rst) // RULE_06
    addr_latch && !write_strobe_n && byte_idx_ff == last_idx_ff && last_idx_ff != 3'h0
    |-> io_out[7:1] == 7'h00)
    else $error("unused address bits not low");

  wp_follow_a : assert property (@(posedge mclk) disable iff (rst) // RULE_01
    !wp_allow |=> !wprot_n)
    else $error("write protect not asserted");

  wait_rdy_a : assert property (@(posedge mclk) disable iff (rst) // RULE_02
    state_ff == NFC_WAITRDY && rb_ready |=> state_ff == NFC_IDLE)
    else $error("ready release missed");
endmodule : nfc_host

/* verif/nfc_flash_model.sv */
/*
  nfc_flash_model: behavioural flash device on the far side of nfc_host.
  assumes: host pins arrive unbuffered; busy times are plain delays.
*/
`timescale 1ns/1ps
module nfc_flash_model
  import nfc_pkg::*;
#(
  parameter int unsigned BUSY_NS = 400
) (
  // host-driven pins
  input  wire logic       chip_en_n,
  input  wire logic       cmd_latch,
  input  wire logic       addr_latch,
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic       wprot_n,
  input  wire logic [7:0] io_out,
  // device-driven pins
  output logic      [7:0] io_in,
  output logic            rdy_busy_n
);
  logic [9:0] log_q[$];  // captured bytes, {kind, byte}: 0 cmd, 1 addr, 2 data
  logic       busy;      // operation in progress
  logic       half;      // page half chosen by the last command byte
  logic [7:0] cmd_ff;    // last command byte
  logic [8:0] ptr_ff;    // column pointer of the page register
  int         n_addr;    // address cycles since the last command

  initial begin
    busy   = 1'b0;
    half   = 1'b0;
    cmd_ff = 8'h00;
    ptr_ff = 9'h000;
    n_addr = 0;
    io_in  = 8'h5A;
  end

  // status pin
  // open drain with pull-up: never floats, and chip enable has no say
  assign rdy_busy_n = busy ? 1'b0 : 1'b1;

  // busy for a fixed span; an overlapping start does not extend it, the earliest span ends it
  task automatic go_busy();
    fork
      begin
        busy = 1'b1;
        #(BUSY_NS);
        busy = 1'b0;
      end
    join_none
  endtask : go_busy

  always @(posedge write_strobe_n) begin
    if (chip_en_n === 1'b0) begin
      if (cmd_latch === 1'b1) begin
        log_q.push_back({2'h0, io_out});
        cmd_ff = io_out;
        n_addr = 0;
        // half select, reverts on any other command
        half   = (io_out == CMD_READ_B);
        // confirm only starts with protection off
        if ((io_out == CMD_PROG_TRUE || io_out == CMD_ERASE_CONF) && wprot_n === 1'b1) begin
          go_busy();
        end
      end else if (addr_latch === 1'b1) begin
        log_q.push_back({2'h1, io_out});
        if (n_addr == 0) begin
          ptr_ff = {half, io_out};
        end
        n_addr++;
        // only the fourth cycle starts a read
        if (n_addr == 4 && (cmd_ff == CMD_READ_A || cmd_ff == CMD_READ_B)) begin
          go_busy();
        end
      end else begin
        log_q.push_back({2'h2, io_out});
      end
    end
  end

  // data out on read strobe fall, pointer advances
  always @(negedge read_strobe_n) begin
    if (chip_en_n === 1'b0) begin
      io_in  = ptr_ff[7:0] ^ {ptr_ff[8], 7'h00};
      ptr_ff = ptr_ff + 9'h001;
    end
  end

  // released bus shows the inverse so a stale byte cannot pass
  always @(posedge read_strobe_n) begin
    io_in = ~io_in;
  end
endmodule : nfc_flash_model

/* verif/tb_top.sv */
/*
  tb_top: self-checking bench of nfc_host against nfc_flash_model.
  assumes: 250 MHz mclk; inputs change on the falling edge.
*/
`timescale 1ns/1ps
module tb_top
  import nfc_pkg::*;
;
  // clock, reset and request side
  logic                 mclk, rst, req_valid, wp_allow, wd_valid;
  nfc_op_t              req_op;
  logic [7:0]           req_cmd, wd_data;
  logic [ADDR_BITS-1:0] req_addr, a;
  logic [9:0]           req_len;
  // design outputs and flash pins
  logic                 req_ready, wd_ready, rd_valid, busy_seen, refused, io_oe, rdy_busy_n;
  logic                 chip_en_n, cmd_latch, addr_latch, write_strobe_n, read_strobe_n, wprot_n;
  logic [7:0]           rd_data, io_out, io_in, c;
  // bench bookkeeping
  int                   n_fail, checks_done, k, n;
  logic [31:0]          seed;
  logic [7:0]           rd_q[$], wd_q[$];
  logic [7:0]           codes[7];

  nfc_host DUT (
    .mclk(mclk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
    .req_cmd(req_cmd), .req_addr(req_addr), .req_len(req_len), .wp_allow(wp_allow),
    .wd_valid(wd_valid), .wd_ready(wd_ready), .wd_data(wd_data), .rd_valid(rd_valid),
    .rd_data(rd_data), .busy_seen(busy_seen), .refused(refused), .chip_en_n(chip_en_n),
    .cmd_latch(cmd_latch), .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .wprot_n(wprot_n), .io_out(io_out), .io_oe(io_oe),
    .io_in(io_in), .rdy_busy_n(rdy_busy_n));

  nfc_flash_model FLASH (
    .chip_en_n(chip_en_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .wprot_n(wprot_n),
    .io_out(io_out), .io_in(io_in), .rdy_busy_n(rdy_busy_n));

  // free-running clock
  always #2 mclk = ~mclk;

  // read bytes are single-cycle pulses, caught mid-cycle
  always @(negedge mclk) begin
    if (rd_valid === 1'b1) begin
      rd_q.push_back(rd_data);
    end
  end

  // xorshift source, fixed start for repeatable runs
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // byte the device should return at a pointer
  function automatic logic [7:0] rd_exp(logic [8:0] p);
    return p[7:0] ^ {p[8], 7'h00};
  endfunction : rd_exp

  task automatic conclude();
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  task automatic chk_v(string what, logic [9:0] exp, logic [9:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk_v

  task automatic chk_f(string what, logic exp, logic got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : chk_f

  // next byte seen on the pins, in order
  task automatic chk_log(logic [1:0] kind, logic [7:0] b);
    logic [9:0] got;
    got = (FLASH.log_q.size() > 0) ? FLASH.log_q.pop_front() : 10'h3FF;
    chk_v("pin byte", {kind, b}, got);
  endtask : chk_log

  // address bytes, column first, spare bits low
  task automatic chk_addr(logic [ADDR_BITS-1:0] x, logic col);
    if (col) chk_log(2'h1, x[7:0]);
    chk_log(2'h1, x[16:9]);
    chk_log(2'h1, x[24:17]);
    chk_log(2'h1, {7'h00, x[25]});
  endtask : chk_addr

  // one request: wait for ready, held one cycle, then wait for idle, bounded
  task automatic issue(nfc_op_t op, logic [7:0] cm, logic [ADDR_BITS-1:0] ad, logic [9:0] ln);
    int i;
    i = 0;
    while (req_ready !== 1'b1 && i < 5000) begin
      @(negedge mclk);
      i++;
    end
    req_valid = 1'b1;
    req_op    = op;
    req_cmd   = cm;
    req_addr  = ad;
    req_len   = ln;
    @(negedge mclk);
    req_valid = 1'b0;
    @(negedge mclk);
    i = 0;
    while (req_ready !== 1'b1 && i < 5000) begin
      @(negedge mclk);
      i++;
    end
    chk_f("request done", 1'b1, req_ready);
  endtask : issue

  // hang guard, far beyond the expected run length
  initial begin
    #300000;
    n_fail++;
    conclude();
  end

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    req_valid = 1'b0;
    req_op = NFC_OP_CMD;
    req_cmd = 8'h00;
    req_addr = '0;
    req_len = '0;
    wp_allow = 1'b1;
    wd_valid = 1'b0;
    wd_data = 8'h00;
    n_fail = 0;
    checks_done = 0;
    seed = 32'd54633;
    codes = '{CMD_READ_A, CMD_READ_B, CMD_READ_SPARE, CMD_READ_ID, CMD_STATUS,
              CMD_MP_STATUS, CMD_RESET};
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    repeat (3) @(negedge mclk);
    chk_f("write protect pin", 1'b1, wprot_n);
    // every single-cycle code goes out with the command latch
    foreach (codes[j]) begin
      issue(NFC_OP_CMD, codes[j], '0, '0);
      chk_log(2'h0, codes[j]);
    end
    // page reads, both halves, random address
    for (k = 0; k < 3; k++) begin
      a = xs();
      c = (k == 1) ? CMD_READ_A : CMD_READ_B;
      issue(NFC_OP_ADDR4, c, a, '0);
      chk_log(2'h0, c);
      chk_addr(a, 1'b1);
      repeat (4) @(negedge mclk);
      chk_f("busy seen", 1'b1, busy_seen);
      issue(NFC_OP_WAIT, '0, '0, '0);
      rd_q.delete();
      issue(NFC_OP_RDATA, '0, '0, 10'd4);
      chk_v("read count", 10'd4, 10'(rd_q.size()));
      for (n = 0; n < 4 && n < rd_q.size(); n++)
        chk_v("read byte", {2'h0, rd_exp({c[0], a[7:0]} + 9'(n))}, {2'h0, rd_q[n]});
    end
    // erase, then a refused and an accepted command while busy
    a = xs();
    issue(NFC_OP_ADDR3, CMD_ERASE_SETUP, a, '0);
    chk_log(2'h0, CMD_ERASE_SETUP);
    chk_addr(a, 1'b0);
    issue(NFC_OP_CMD, CMD_ERASE_CONF, '0, '0);
    chk_log(2'h0, CMD_ERASE_CONF);
    repeat (4) @(negedge mclk);
    chk_f("busy seen", 1'b1, busy_seen);
    req_valid = 1'b1;
    req_op = NFC_OP_CMD;
    req_cmd = CMD_READ_ID;
    repeat (2) @(negedge mclk);
    chk_f("refused", 1'b1, refused);
    req_valid = 1'b0;
    repeat (3) @(negedge mclk);
    chk_v("bytes while refused", 10'd0, 10'(FLASH.log_q.size()));
    issue(NFC_OP_CMD, CMD_STATUS, '0, '0);
    chk_log(2'h0, CMD_STATUS);
    issue(NFC_OP_WAIT, '0, '0, '0);
    chk_f("ready pin", 1'b1, rdy_busy_n);
    // fill the write fifo until it refuses, then program a page
    n = 0;
    for (k = 0; k < 10; k++) begin
      wd_valid = (wd_ready === 1'b1);
      if (wd_valid) begin
        wd_data = xs();
        wd_q.push_back(wd_data);
        n++;
      end
      @(negedge mclk);
    end
    chk_v("fifo accepted", 10'd8, 10'(n));
    chk_f("fifo full", 1'b0, wd_ready);
    a = xs();
    issue(NFC_OP_ADDR4, CMD_PROG_SETUP, a, '0);
    issue(NFC_OP_WDATA, '0, '0, 10'd8);
    issue(NFC_OP_CMD, CMD_PROG_TRUE, '0, '0);
    chk_log(2'h0, CMD_PROG_SETUP);
    chk_addr(a, 1'b1);
    foreach (wd_q[j]) chk_log(2'h2, wd_q[j]);
    chk_log(2'h0, CMD_PROG_TRUE);
    repeat (4) @(negedge mclk);
    chk_f("busy seen", 1'b1, busy_seen);
    issue(NFC_OP_WAIT, '0, '0, '0);
    // protection held: erase must not start
    wp_allow = 1'b0;
    repeat (4) @(negedge mclk);
    chk_f("write protect pin", 1'b0, wprot_n);
    issue(NFC_OP_ADDR3, CMD_ERASE_SETUP, xs(), '0);
    issue(NFC_OP_CMD, CMD_ERASE_CONF, '0, '0);
    repeat (4) @(negedge mclk);
    chk_f("busy seen", 1'b0, busy_seen);
    conclude();
  end
endmodule : tb_top
